// ==== verilog/sdsr_regs.svh ====
/*
 * register offsets, field positions, reset values and the build-time
 * slave address map of the secure default-slave router.
 * assumes: included by its bare name from the router.
 */
`ifndef SDSR_REGS_SVH
`define SDSR_REGS_SVH
// apb register byte offsets
`define SDSR_CTRL_OFS      12'h000
`define SDSR_STATUS_OFS    12'h004
`define SDSR_MASK_OFS      12'h008
`define SDSR_ERRADDR_OFS   12'h00c
`define SDSR_ERRCNT_OFS    12'h010
// ctrl fields and reset values
`define SDSR_CTRL_DFLT_BIT 0
`define SDSR_CTRL_RST      32'h0000_0001
`define SDSR_MASK_RST      4'h0
// status / mask bit positions
`define SDSR_EV_SEC        0
`define SDSR_EV_GAP        1
`define SDSR_EV_OUT        2
`define SDSR_EV_DIR        3
// decode-error response code
`define SDSR_RESP_DECERR   2'h3
// slave address map, inclusive low and high
`define SDSR_NSLV          6
`define SDSR_S0_BASE       32'h0000_0000
`define SDSR_S0_LAST       32'h0000_0fff
`define SDSR_S1_BASE       32'h0000_2000
`define SDSR_S1_LAST       32'h0000_2fff
`define SDSR_S2_BASE       32'h0001_0000
`define SDSR_S2_LAST       32'h0001_ffff
`define SDSR_S3_BASE       32'h0002_0000
`define SDSR_S3_LAST       32'h0002_00ff
`define SDSR_S4_BASE       32'h0003_0000
`define SDSR_S4_LAST       32'h0003_00ff
`define SDSR_S5_BASE       32'h0004_0000
`define SDSR_S5_LAST       32'h0004_0fff
// secure range inside slave 2
`define SDSR_S2_SEC_LO     32'h0001_0000
`define SDSR_S2_SEC_HI     32'h0001_0fff
// slaves reachable from the master: slave 5 is not
`define SDSR_CONN_MASK     6'h1f
`endif

// ==== verilog/sdsr_pkg.sv ====
/*
 * types of the secure default-slave router.
 * assumes: nothing beyond a systemverilog compiler.
 */
`default_nettype none
package sdsr_pkg;
    typedef enum logic [1:0] {SM_AWARE, SM_SECURE, SM_NONSEC, SM_RANGES} sdsr_smode_t;
    typedef enum logic [1:0] {DIR_RW, DIR_RO, DIR_WO} sdsr_dir_t;
    typedef enum logic [1:0] {MK_AWARE, MK_SECURE, MK_NONSEC} sdsr_mkind_t;
    typedef enum logic [1:0] {ST_IDLE, ST_REAL, ST_DFLT} sdsr_state_t;
endpackage : sdsr_pkg
`default_nettype wire

// ==== verilog/sdsr_router.sv ====
/*
 * address decode, security check and built-in default slave for one
 * master port of a memory-mapped interconnect, with an apb register file.
 * assumes: one clock, requests synchronous to pclk, one beat per
 * handshake, slave responses other than the default slave's return
 * outside this block.
 */
// Functional notes
// - security violations go to the default slave, which answers with error.
// - a default slave exists whenever per-access or forbidden traffic can occur.
// - one default slave serves every master of the domain; here each router has its own.
// - access matrix: aware/non-secure slaves open, secure slaves checked.
// - address outside every slave of the master's map goes to default.
// - gaps inside the slaves' span decode as undefined, go to default.
// - region of a slave not connected to this master is undefined.
// - non-secure access to build-time secure slave is undefined.
// - write to read-only or read to write-only slave is undefined.
// - without designated default, lowest-address slave of the map serves.
// - masters without protection bit count as non-secure unless set otherwise.
// - secure master sends only secure; secure slave takes only secure.
// - only listed inclusive ranges of a range slave are secure.
`include "sdsr_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sdsr_router #(
    parameter sdsr_pkg::sdsr_mkind_t MST_KIND = sdsr_pkg::MK_AWARE
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        m_valid,
    output logic             m_ready,
    input  wire logic [31:0] m_addr,
    input  wire logic        m_write,
    input  wire logic        m_prot_ns,
    input  wire logic [3:0]  m_id,
    input  wire logic        m_last,
    output logic      [5:0]  s_valid,
    input  wire logic [5:0]  s_ready,
    output logic      [31:0] s_addr,
    output logic             s_write,
    output logic             s_prot_ns,
    output logic      [3:0]  s_id,
    output logic             s_last,
    output logic             ds_rvalid,
    input  wire logic        ds_rready,
    output logic      [1:0]  ds_rresp,
    output logic      [31:0] ds_rdata,
    output logic      [3:0]  ds_rid,
    output logic             ds_rlast,
    output logic             ds_rwrite
);
    localparam int N = `SDSR_NSLV;
    localparam logic [31:0] BASE [N] = '{`SDSR_S0_BASE, `SDSR_S1_BASE, `SDSR_S2_BASE,
                                         `SDSR_S3_BASE, `SDSR_S4_BASE, `SDSR_S5_BASE};
    localparam logic [31:0] LAST [N] = '{`SDSR_S0_LAST, `SDSR_S1_LAST, `SDSR_S2_LAST,
                                         `SDSR_S3_LAST, `SDSR_S4_LAST, `SDSR_S5_LAST};
    localparam sdsr_pkg::sdsr_smode_t SMODE [N] = '{sdsr_pkg::SM_AWARE,
        sdsr_pkg::SM_SECURE, sdsr_pkg::SM_RANGES, sdsr_pkg::SM_NONSEC,
        sdsr_pkg::SM_NONSEC, sdsr_pkg::SM_NONSEC};
    localparam sdsr_pkg::sdsr_dir_t SDIR [N] = '{sdsr_pkg::DIR_RW, sdsr_pkg::DIR_RW,
        sdsr_pkg::DIR_RW, sdsr_pkg::DIR_RO, sdsr_pkg::DIR_WO, sdsr_pkg::DIR_RW};
    localparam logic [N-1:0] CONN = `SDSR_CONN_MASK;

    sdsr_pkg::sdsr_state_t state;
    sdsr_pkg::sdsr_state_t next_state;
    logic [2:0]  lat_idx;
    logic        ctrl_dflt_en;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [31:0] err_addr;
    logic [31:0] err_cnt;

    // transaction security class of the issuing master
    logic txn_sec;
    always_comb begin
        case (MST_KIND)
            sdsr_pkg::MK_SECURE: txn_sec = 1'b1;
            sdsr_pkg::MK_NONSEC: txn_sec = 1'b0;
            default:             txn_sec = ~m_prot_ns;
        endcase
    end

    // per-slave decode; loops unroll into one comparator pair per slave
    logic       hit_any;
    logic       conn_hit;
    logic       needs_sec;
    logic       dir_bad;
    logic [2:0] hit_idx;
    logic [2:0] lowest_idx;
    logic [31:0] span_lo;
    logic [31:0] span_hi;
    always_comb begin
        hit_any    = 1'b0;
        conn_hit   = 1'b0;
        needs_sec  = 1'b0;
        dir_bad    = 1'b0;
        hit_idx    = 3'h0;
        lowest_idx = 3'h0;
        span_lo    = 32'hffff_ffff;
        span_hi    = 32'h0000_0000;
        for (int i = 0; i < N; i++) begin
            if (CONN[i] && BASE[i] <= span_lo) begin
                span_lo    = BASE[i];
                lowest_idx = 3'(i);
            end
            if (CONN[i] && LAST[i] > span_hi) begin
                span_hi = LAST[i];
            end
            if (m_addr >= BASE[i] && m_addr <= LAST[i]) begin
                hit_any   = 1'b1;
                hit_idx   = 3'(i);
                conn_hit  = CONN[i];
                // secure-only for build-time secure slaves and listed ranges
                needs_sec = (SMODE[i] == sdsr_pkg::SM_SECURE) ||
                            (SMODE[i] == sdsr_pkg::SM_RANGES &&
                             m_addr >= `SDSR_S2_SEC_LO && m_addr <= `SDSR_S2_SEC_HI);
                dir_bad   = (SDIR[i] == sdsr_pkg::DIR_RO && m_write) ||
                            (SDIR[i] == sdsr_pkg::DIR_WO && !m_write);
            end
        end
    end

    // failure causes; only one is flagged, security first
    wire cause_gap = !hit_any && m_addr >= span_lo && m_addr <= span_hi;
    wire cause_out = (!hit_any && !cause_gap) || (hit_any && !conn_hit);
    wire cause_sec = hit_any && conn_hit && needs_sec && !txn_sec;
    wire cause_dir = hit_any && conn_hit && !cause_sec && dir_bad;
    wire reject    = cause_gap | cause_out | cause_sec | cause_dir;

    // routing: a burst stays on the target chosen at its first beat
    wire       is_first    = (state == sdsr_pkg::ST_IDLE);
    wire       to_dflt_cur = is_first ? (reject && ctrl_dflt_en)
                                      : (state == sdsr_pkg::ST_DFLT);
    wire [2:0] tgt_first   = reject ? lowest_idx : hit_idx;
    wire [2:0] tgt_cur     = is_first ? tgt_first : lat_idx;
    wire       ds_can      = !ds_rvalid || ds_rready;
    wire       beat        = m_valid && m_ready;
    wire       first_beat  = beat && is_first;
    wire       rsp_now     = beat && to_dflt_cur && (!m_write || m_last);

    assign m_ready   = to_dflt_cur ? ds_can : s_ready[tgt_cur];
    assign s_addr    = m_addr;
    assign s_write   = m_write;
    assign s_prot_ns = ~txn_sec;
    assign s_id      = m_id;
    assign s_last    = m_last;
    always_comb begin
        s_valid = 6'h00;
        if (m_valid && !to_dflt_cur) begin
            s_valid[tgt_cur] = 1'b1;
        end
    end

    // burst state
    always_comb begin
        next_state = state;
        case (state)
            sdsr_pkg::ST_IDLE: begin
                if (beat && !m_last) begin
                    next_state = to_dflt_cur ? sdsr_pkg::ST_DFLT : sdsr_pkg::ST_REAL;
                end
            end
            sdsr_pkg::ST_REAL,
            sdsr_pkg::ST_DFLT: begin
                if (beat && m_last) begin
                    next_state = sdsr_pkg::ST_IDLE;
                end
            end
            default: next_state = sdsr_pkg::ST_IDLE;
        endcase
    end

    // state and target latch; the target moves only on a first beat
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= sdsr_pkg::ST_IDLE;
            lat_idx <= 3'h0;
        end else begin
            state <= next_state;
            if (first_beat) begin
                lat_idx <= tgt_first;
            end
        end
    end

    // default slave: one response register, reads every beat, writes once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ds_rvalid <= 1'b0;
            ds_rid    <= 4'h0;
            ds_rlast  <= 1'b0;
            ds_rwrite <= 1'b0;
        end else if (rsp_now) begin
            ds_rvalid <= 1'b1;
            ds_rid    <= m_id;
            ds_rlast  <= m_last;
            ds_rwrite <= m_write;
        end else if (ds_rready) begin
            ds_rvalid <= 1'b0;
        end
    end
    // constant error answer; nothing reaches a real slave
    assign ds_rresp = `SDSR_RESP_DECERR;
    assign ds_rdata = 32'h0000_0000;

    // apb decode; zero wait states
    wire        acc      = psel && penable;
    wire        wr       = acc && pwrite;
    wire        sel_ctrl = (paddr == `SDSR_CTRL_OFS);
    wire        sel_stat = (paddr == `SDSR_STATUS_OFS);
    wire        sel_mask = (paddr == `SDSR_MASK_OFS);
    wire        sel_ea   = (paddr == `SDSR_ERRADDR_OFS);
    wire        sel_ec   = (paddr == `SDSR_ERRCNT_OFS);
    wire        mapped   = sel_ctrl | sel_stat | sel_mask | sel_ea | sel_ec;
    wire [3:0]  ev       = first_beat ? {cause_dir, cause_out, cause_gap, cause_sec} : 4'h0;
    wire [3:0]  w1c      = (wr && sel_stat) ? pwdata[3:0] : 4'h0;
    assign pready  = 1'b1;
    assign pslverr = acc && !mapped;
    assign irq     = |(status & mask);
    assign prdata  = sel_ctrl ? {31'h0, ctrl_dflt_en} :
                     sel_stat ? {28'h0, status} :
                     sel_mask ? {28'h0, mask} :
                     sel_ea   ? err_addr :
                     sel_ec   ? err_cnt : 32'h0000_0000;

    // registers; a new event wins over a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_dflt_en <= 1'(`SDSR_CTRL_RST);
            mask         <= `SDSR_MASK_RST;
            status       <= 4'h0;
            err_addr     <= 32'h0000_0000;
            err_cnt      <= 32'h0000_0000;
        end else begin
            if (wr && sel_ctrl) begin
                ctrl_dflt_en <= pwdata[`SDSR_CTRL_DFLT_BIT];
            end
            if (wr && sel_mask) begin
                mask <= pwdata[3:0];
            end
            status <= (status & ~w1c) | ev;
            if (first_beat && reject) begin
                err_addr <= m_addr;
                err_cnt  <= err_cnt + 32'h0000_0001;
            end
        end
    end

    // checks beside the routing, the default slave and the event record
    a_dflt_err_resp: assert property (@(posedge pclk) disable iff (!presetn)
        beat && to_dflt_cur && (!m_write || m_last) |=>
            ds_rvalid && ds_rresp == `SDSR_RESP_DECERR && ds_rdata == 32'h0)
        else $error("default slave answer is not a zeroed decode error");
    a_reject_to_dflt: assert property (@(posedge pclk) disable iff (!presetn)
        m_valid && is_first && reject && ctrl_dflt_en |-> s_valid == 6'h00)
        else $error("rejected request reached a real slave");
    a_lowest_fallback: assert property (@(posedge pclk) disable iff (!presetn)
        m_valid && is_first && reject && !ctrl_dflt_en |-> s_valid[lowest_idx])
        else $error("rejected request not sent to lowest slave");
    a_nonsec_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        m_valid && is_first && conn_hit && needs_sec && !txn_sec |-> reject && cause_sec)
        else $error("non-secure access to secure slave passed");
    a_dir_blocked: assert property (@(posedge pclk) disable iff (!presetn)
        m_valid && is_first && conn_hit && dir_bad && !cause_sec |-> reject)
        else $error("wrong-direction access passed");
    a_gap_flag: assert property (@(posedge pclk) disable iff (!presetn)
        first_beat && cause_gap |=> status[`SDSR_EV_GAP] ##0 err_cnt == $past(err_cnt) + 1)
        else $error("gap access not recorded");
    a_read_rsp_id: assert property (@(posedge pclk) disable iff (!presetn)
        beat && to_dflt_cur && !m_write |=> ds_rvalid && ds_rid == $past(m_id))
        else $error("read beat lacks a default-slave answer");
    a_rsp_hold: assert property (@(posedge pclk) disable iff (!presetn)
        ds_rvalid && !ds_rready |=> ds_rvalid && $stable(ds_rid) && $stable(ds_rlast))
        else $error("default-slave answer dropped before taken");
    a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
        first_beat && cause_sec && mask[`SDSR_EV_SEC] |=> irq)
        else $error("security event did not raise interrupt");
    a_burst_lock: assert property (@(posedge pclk) disable iff (!presetn)
        state == sdsr_pkg::ST_DFLT && m_valid |-> s_valid == 6'h00)
        else $error("redirected burst leaked to a real slave");
    a_out_flag: assert property (@(posedge pclk) disable iff (!presetn)
        first_beat && cause_out |=> status[`SDSR_EV_OUT])
        else $error("outside-map access not recorded");
    a_dir_flag: assert property (@(posedge pclk) disable iff (!presetn)
        first_beat && cause_dir |=> status[`SDSR_EV_DIR])
        else $error("wrong-direction access not recorded");
    a_write_no_answer: assert property (@(posedge pclk) disable iff (!presetn)
        beat && to_dflt_cur && m_write && !m_last && !ds_rvalid |=> !ds_rvalid)
        else $error("inner write beat got an answer");
endmodule : sdsr_router
`default_nettype wire

// ==== verif/sdsr_master_model.sv ====
/*
 * master-side model: issues beats on the master channel and takes the
 * default-slave answers after a settable delay.
 * assumes: pclk from the bench, beat called just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module sdsr_master_model (
    input  wire logic        pclk,
    output logic             m_valid,
    input  wire logic        m_ready,
    output logic      [31:0] m_addr,
    output logic             m_write,
    output logic             m_prot_ns,
    output logic      [3:0]  m_id,
    output logic             m_last,
    input  wire logic [5:0]  s_valid,
    input  wire logic [31:0] s_addr,
    input  wire logic        s_write,
    input  wire logic        s_prot_ns,
    input  wire logic [3:0]  s_id,
    input  wire logic        s_last,
    input  wire logic        ds_rvalid,
    output logic             ds_rready,
    input  wire logic [1:0]  ds_rresp,
    input  wire logic [31:0] ds_rdata,
    input  wire logic [3:0]  ds_rid,
    input  wire logic        ds_rlast,
    input  wire logic        ds_rwrite
);
    int          delay = 0;
    int          n_ans = 0;
    int          n_to  = 0;
    int          wcnt  = 0;
    logic [5:0]  seen_sv;
    logic [38:0] seen_fwd;
    logic [39:0] got;

    initial begin
        {m_valid, m_addr, m_write, m_prot_ns, m_id, m_last, ds_rready} = '0;
    end

    // answer side; a delay stalls the default slave like a slow master
    always @(posedge pclk) begin
        if (ds_rvalid && ds_rready) begin
            got <= {ds_rresp, ds_rid, ds_rlast, ds_rwrite, ds_rdata};
            n_ans <= n_ans + 1;
            ds_rready <= 1'h0;
            wcnt <= 0;
        end else if (ds_rvalid) begin
            if (wcnt >= delay) ds_rready <= 1'h1;
            wcnt <= wcnt + 1;
        end
    end

    // one beat, held until taken; the target seen is kept
    task automatic beat(input logic [31:0] a, input logic w, input logic ns,
                        input logic [3:0] id, input logic l);
        logic tk;
        tk = 1'h0;
        m_valid <= 1'h1;
        m_addr <= a;
        m_write <= w;
        m_prot_ns <= ns;
        m_id <= id;
        m_last <= l;
        for (int i = 0; i < 200 && !tk; i++) begin
            @(posedge pclk);
            tk = (m_valid && m_ready) === 1'h1;
            seen_sv = s_valid;
            seen_fwd = {s_prot_ns, s_write, s_last, s_id, s_addr};
        end
        if (!tk) n_to++;
    endtask : beat

    // released address lines show the inverse, not a stale value
    task automatic idle;
        m_valid <= 1'h0;
        m_addr <= ~m_addr;
        @(posedge pclk);
    endtask : idle
endmodule : sdsr_master_model
`default_nettype wire

// ==== verif/sdsr_router_tb.sv ====
/*
 * testbench of the router: apb master, table of routes, interrupt,
 * missing default slave and bursts.
 * assumes: the master model beside it, one clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sdsr_router_tb;
    logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, s_addr, ds_rdata, m_addr, rdat;
    logic        pready, pslverr, irq, m_valid, m_ready, m_write, m_prot_ns, m_last, rerr;
    logic        s_write, s_prot_ns, s_last, ds_rvalid, ds_rready, ds_rlast, ds_rwrite;
    logic [5:0]  s_valid, s_ready = 6'h3f, ns_sv;
    logic        ns_prot;
    logic [6:0]  nsv;
    logic [3:0]  m_id, s_id, ds_rid;
    logic [1:0]  ds_rresp;
    int          n_mismatch = 0, n_tests = 0, exp_ans = 0;
    localparam logic [31:0] RA [12] = '{32'h100, 32'h2004, 32'h11000, 32'h20010,
        32'h30010, 32'h2000, 32'h10ffc, 32'h1000, 32'h40000, 32'h50000, 32'h20000, 32'h30000};
    localparam logic [11:0] RW = 12'h410;
    localparam logic [11:0] NS = 12'h065;
    localparam logic [5:0]  SV [12] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10,
        6'h0, 6'h0, 6'h0, 6'h0, 6'h0, 6'h0, 6'h0};
    localparam int          EV [12] = '{0, 0, 0, 0, 0, 0, 0, 1, 2, 2, 3, 3};

    always #2 pclk = ~pclk;

    sdsr_router u_sdsr_router (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .m_valid(m_valid), .m_ready(m_ready), .m_addr(m_addr),
        .m_write(m_write), .m_prot_ns(m_prot_ns), .m_id(m_id), .m_last(m_last),
        .s_valid(s_valid), .s_ready(s_ready), .s_addr(s_addr), .s_write(s_write),
        .s_prot_ns(s_prot_ns), .s_id(s_id), .s_last(s_last), .ds_rvalid(ds_rvalid),
        .ds_rready(ds_rready), .ds_rresp(ds_rresp), .ds_rdata(ds_rdata), .ds_rid(ds_rid),
        .ds_rlast(ds_rlast), .ds_rwrite(ds_rwrite));
    sdsr_master_model u_sdsr_master_model (.pclk(pclk), .m_valid(m_valid), .m_ready(m_ready),
        .m_addr(m_addr), .m_write(m_write), .m_prot_ns(m_prot_ns), .m_id(m_id),
        .m_last(m_last), .s_valid(s_valid), .s_addr(s_addr), .s_write(s_write),
        .s_prot_ns(s_prot_ns), .s_id(s_id), .s_last(s_last), .ds_rvalid(ds_rvalid),
        .ds_rready(ds_rready), .ds_rresp(ds_rresp), .ds_rdata(ds_rdata), .ds_rid(ds_rid),
        .ds_rlast(ds_rlast), .ds_rwrite(ds_rwrite));
    // second router as a build-time non-secure master on the same beats
    sdsr_router #(.MST_KIND(sdsr_pkg::MK_NONSEC)) u_sdsr_router_ns (.pclk(pclk),
        .presetn(presetn), .paddr(12'h000), .psel(1'h0), .penable(1'h0), .pwrite(1'h0),
        .pwdata(32'h0), .prdata(), .pready(), .pslverr(), .irq(), .m_valid(m_valid),
        .m_ready(), .m_addr(m_addr), .m_write(m_write), .m_prot_ns(m_prot_ns), .m_id(m_id),
        .m_last(m_last), .s_valid(ns_sv), .s_ready(6'h3f), .s_addr(), .s_write(),
        .s_prot_ns(ns_prot), .s_id(), .s_last(), .ds_rvalid(), .ds_rready(1'h1),
        .ds_rresp(), .ds_rdata(), .ds_rid(), .ds_rlast(), .ds_rwrite());

    // its target and class, taken at each beat the main router accepts
    always @(posedge pclk) begin
        if (m_valid && m_ready) begin
            nsv <= {ns_prot, ns_sv};
        end
    end

    task automatic complete_run;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // apb transfer; held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic rd;
        rd = 1'h0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (int i = 0; i < 200 && !rd; i++) begin
            @(posedge pclk);
            rd = pready === 1'h1;
            if (rd) begin
                rdat = prdata;
                rerr = pslverr;
            end
        end
        psel <= 1'h0;
        penable <= 1'h0;
        if (!rd) begin
            n_mismatch++;
            complete_run;
        end
    endtask : apb

    task automatic send(input logic [31:0] a, input logic w, input logic ns, input logic [3:0] id);
        @(posedge pclk);
        u_sdsr_master_model.beat(a, w, ns, id, 1'h1);
        u_sdsr_master_model.idle;
    endtask : send

    // bounded wait for the next default-slave answer
    task automatic wait_ans;
        exp_ans++;
        for (int i = 0; i < 200 && u_sdsr_master_model.n_ans < exp_ans; i++) @(posedge pclk);
        if (u_sdsr_master_model.n_ans < exp_ans) begin
            n_mismatch++;
            complete_run;
        end
    endtask : wait_ans

    task automatic t_regs;
        apb(1'h0, 12'h000, 32'h0);
        chk(rdat, 32'h1);
        apb(1'h0, 12'h004, 32'h0);
        chk(rdat, 32'h0);
        apb(1'h0, 12'h008, 32'h0);
        chk(rdat, 32'h0);
        apb(1'h1, 12'h020, 32'hffff_ffff);
        apb(1'h0, 12'h020, 32'h0);
        chk({rerr, rdat}, 33'h1_0000_0000);
    endtask : t_regs

    // legal targets, then every refusal cause, with its status bit
    task automatic t_route;
        for (int i = 0; i < 12; i++) begin
            send(RA[i], RW[i], NS[i], 4'(i));
            chk(u_sdsr_master_model.seen_sv, SV[i]);
            chk(nsv, {1'h1, (i == 1) ? 6'h00 : SV[i]});
            if (SV[i] == 6'h0) begin
                wait_ans;
                chk(u_sdsr_master_model.got, {2'h3, 4'(i), 1'h1, RW[i], 32'h0});
                apb(1'h0, 12'h004, 32'h0);
                chk(rdat, 32'h1 << EV[i]);
                apb(1'h1, 12'h004, 32'hf);
            end else begin
                chk(u_sdsr_master_model.seen_fwd, {NS[i], RW[i], 1'h1, 4'(i), RA[i]});
                @(negedge pclk);
                chk(ds_rvalid, 1'h0);
            end
        end
        apb(1'h0, 12'h010, 32'h0);
        chk(rdat, 32'h7);
        apb(1'h0, 12'h00c, 32'h0);
        chk(rdat, 32'h30000);
    endtask : t_route

    task automatic t_irq;
        apb(1'h1, 12'h008, 32'h3);
        send(32'h1000, 1'h0, 1'h0, 4'h1);
        wait_ans;
        @(negedge pclk);
        chk(irq, 1'h1);
        apb(1'h1, 12'h004, 32'h2);
        @(negedge pclk);
        chk(irq, 1'h0);
        send(32'h40000, 1'h0, 1'h0, 4'h2);
        wait_ans;
        @(negedge pclk);
        chk(irq, 1'h0);
        send(32'h2000, 1'h0, 1'h1, 4'h4);
        wait_ans;
        @(negedge pclk);
        chk(irq, 1'h1);
        apb(1'h1, 12'h004, 32'hf);
        apb(1'h1, 12'h008, 32'h0);
    endtask : t_irq

    // no designated default: the lowest slave of the map takes it
    task automatic t_nodflt;
        apb(1'h1, 12'h000, 32'h0);
        send(32'h1000, 1'h0, 1'h0, 4'h3);
        chk(u_sdsr_master_model.seen_sv, 6'h01);
        @(negedge pclk);
        chk(ds_rvalid, 1'h0);
        apb(1'h1, 12'h004, 32'hf);
        apb(1'h1, 12'h000, 32'h1);
    endtask : t_nodflt

    // bursts with a slow master: one write answer, one per read beat
    task automatic t_burst;
        u_sdsr_master_model.delay = 3;
        @(posedge pclk);
        u_sdsr_master_model.beat(32'h1000, 1'h1, 1'h0, 4'h9, 1'h0);
        u_sdsr_master_model.beat(32'h100, 1'h1, 1'h0, 4'h9, 1'h0);
        chk(u_sdsr_master_model.seen_sv, 6'h0);
        u_sdsr_master_model.beat(32'h104, 1'h1, 1'h0, 4'h9, 1'h1);
        u_sdsr_master_model.beat(32'h50000, 1'h0, 1'h0, 4'h5, 1'h0);
        u_sdsr_master_model.beat(32'h50004, 1'h0, 1'h0, 4'h5, 1'h1);
        u_sdsr_master_model.idle;
        wait_ans;
        wait_ans;
        wait_ans;
        chk(u_sdsr_master_model.got, {2'h3, 4'h5, 1'h1, 1'h0, 32'h0});
        repeat (10) @(posedge pclk);
        chk(u_sdsr_master_model.n_ans, exp_ans);
    endtask : t_burst

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_route;
        t_irq;
        t_nodflt;
        t_burst;
        chk(u_sdsr_master_model.n_to, 0);
        complete_run;
    end
endmodule : sdsr_router_tb
`default_nettype wire
